// >>> hw/mlc_cfg.svh
// Constants for the memory command controller
`ifndef MLC_CFG_SVH
`define MLC_CFG_SVH
`define MLC_CMD_PROG      8'h40
`define MLC_CMD_LOCK_SET  8'h60
`define MLC_CMD_LOCK_CLR  8'h60
`define MLC_CFM_LOCK_SET  8'h01
`define MLC_CFM_LOCK_CLR  8'hd0
`define MLC_CMD_RCFG_SETUP 8'h60
`define MLC_CFM_RCFG      8'h03
`define MLC_CMD_CLR_STAT  8'h50
`define MLC_CMD_RD_STAT   8'h70
`define MLC_CMD_RD_ARRAY  8'hff
`define MLC_SR_READY      7
`define MLC_SR_PROG_FAIL  4
`define MLC_SR_VOLT_FAIL  3
`define MLC_SR_PROT_FAIL  1
`define MLC_RCFG_MODE_BIT 15
`define MLC_REG_CTRL      4'h0
`define MLC_REG_ADDR      4'h1
`define MLC_REG_DATA      4'h2
`define MLC_REG_STAT      4'h3
`define MLC_REG_EVT       4'h4
`define MLC_REG_MASK      4'h5
`define MLC_REG_RDATA     4'h6
`define MLC_OP_PROG       3'h1
`define MLC_OP_LOCK_SET   3'h2
`define MLC_OP_LOCK_CLR   3'h3
`define MLC_OP_RCFG       3'h4
`define MLC_OP_READ       3'h5
`define MLC_OP_CLR_STAT   3'h6
`define MLC_PHASE_CYC     2
`endif

// >>> hw/mlc_host.sv
// Host controller driving the memory over its asynchronous pins
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`include "mlc_cfg.svh"
// Rules taken from the document
// R01: Array reads use single accesses; status reads are single accesses only.
// R02: Read mode bit 15 of read_config_reg: 0 standard, 1 page mode.
// R03: Host writes zero into read_config_reg bits 14 down to 1.
// R04: Set lock bit: write 60H, then confirm carrying an address in the block.
// R05: Device refuses lock commands while busy or suspended.
// R06: After a lock command reads give status; ready shows via pin and flag.
// R07: One clear-lock-bits sequence unlocks every block.
// R08: Clear-lock aborted by supply loss is reissued to restore lock bits.
// R09: Device command latch ignores chip-select and state machine activity.
// R10: Device returns to read-array at power-up, power-down exit, lockout.
// R11: Toggling output enable low-high-low refreshes latched status.
// R12: Full status check after each program or after a series.
// R13: After final program host writes FFH; device returns to read array.
// R14: Fail flags stay set until the clear-status command.
// R15: Host clears status after an error before any retry.
// R16: Program is 40H setup then a write carrying address and data.
// R17: Ready flag 1 when idle, 0 busy; other bits undriven while busy.
// R18: Writing 50H clears the error flags; only way to reset them.
// R19: 70H selects read-status; device also enters it when an operation starts.
module mlc_host (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [3:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [31:0]            reg_rdata,
    output logic                   irq,
    output mlc_pkg::mlc_bus_s      mem_bus,
    input  wire logic [15:0]       mem_dq_in,
    input  wire logic              mem_ready_pin
);
    import mlc_pkg::*;

    logic [15:0] dq_s1_ff, dq_s2_ff;
    logic        rdy_s1_ff, rdy_s2_ff;
    mlc_st_e     st_ff, nxt_st;
    logic [2:0]  op_ff;
    logic        series_ff;
    logic [22:0] addr_ff;
    logic [15:0] data_ff;
    logic [1:0]  ph_ff;
    logic [7:0]  stat_ff;
    logic [15:0] rdata_ff;
    logic [2:0]  evt_ff, mask_ff;
    logic        busy_ff;
    logic        arm_ff;
    mlc_bus_s    bus_ff, nxt_bus;

    // Pin inputs cross in through two flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dq_s1_ff  <= 16'h0000;
            dq_s2_ff  <= 16'h0000;
            rdy_s1_ff <= 1'b0;
            rdy_s2_ff <= 1'b0;
        end else begin
            dq_s1_ff  <= mem_dq_in;
            dq_s2_ff  <= dq_s1_ff;
            rdy_s1_ff <= mem_ready_pin;
            rdy_s2_ff <= rdy_s1_ff;
        end
    end

    // Control word: [2:0] op, [3] series (skip FFH exit), [15] page mode
    wire ctrl_wr   = reg_wr && reg_addr == `MLC_REG_CTRL;
    wire start     = ctrl_wr && !busy_ff && reg_wdata[2:0] != 3'h0;
    wire evt_rd    = reg_rd && reg_addr == `MLC_REG_EVT;
    wire ph_last   = ph_ff == 2'(`MLC_PHASE_CYC - 1);
    wire dev_ready = dq_s2_ff[`MLC_SR_READY] && rdy_s2_ff;                           // [R06] [R17]
    wire any_err   = |{dq_s2_ff[`MLC_SR_PROG_FAIL], dq_s2_ff[`MLC_SR_VOLT_FAIL],
                       dq_s2_ff[`MLC_SR_PROT_FAIL]};
    wire rd_done   = st_ff == ST_READ && ph_last && arm_ff;
    wire [2:0] evt_set = {st_ff == ST_CHECK && ph_last && any_err,
                          st_ff == ST_CHECK && ph_last,
                          rd_done};

    function automatic logic [7:0] first_code(input logic [2:0] op);
        unique case (op)
            `MLC_OP_PROG:     first_code = `MLC_CMD_PROG;                            // [R16]
            `MLC_OP_LOCK_SET: first_code = `MLC_CMD_LOCK_SET;                        // [R04]
            `MLC_OP_LOCK_CLR: first_code = `MLC_CMD_LOCK_CLR;                        // [R07] [R08]
            `MLC_OP_RCFG:     first_code = `MLC_CMD_RCFG_SETUP;
            `MLC_OP_CLR_STAT: first_code = `MLC_CMD_CLR_STAT;                        // [R18] [R15]
            default:          first_code = `MLC_CMD_RD_ARRAY;                        // [R10]
        endcase
    endfunction

    function automatic logic [15:0] second_word(input logic [2:0] op, input logic [15:0] d);
        unique case (op)
            `MLC_OP_LOCK_SET: second_word = {8'h00, `MLC_CFM_LOCK_SET};
            `MLC_OP_LOCK_CLR: second_word = {8'h00, `MLC_CFM_LOCK_CLR};
            `MLC_OP_RCFG:     second_word = {8'h00, `MLC_CFM_RCFG};
            default:          second_word = d;
        endcase
    endfunction

    // Read-config value rides on the address; reserved bits forced low
    wire [22:0] rcfg_addr = {7'h00, data_ff[`MLC_RCFG_MODE_BIT], 15'h0000};           // [R02] [R03]
    wire [22:0] w2_addr  = op_ff == `MLC_OP_RCFG ? rcfg_addr : addr_ff;               // [R04]
    wire        two_cyc  = op_ff inside {`MLC_OP_PROG, `MLC_OP_LOCK_SET, `MLC_OP_LOCK_CLR, `MLC_OP_RCFG};

    // Each phase lasts the full phase count; the W1, W2, EXIT and POLL strobes rise in its last cycle
    always_comb begin
        nxt_st  = st_ff;
        nxt_bus = bus_ff;
        nxt_bus.ce_n  = 1'b1;
        nxt_bus.oe_n  = 1'b1;
        nxt_bus.we_n  = 1'b1;
        nxt_bus.dq_oe = 1'b0;
        unique case (st_ff)
            ST_IDLE: begin
                if (start) begin
                    nxt_st = reg_wdata[2:0] == `MLC_OP_READ ? ST_READ : ST_W1;
                end
            end
            ST_W1: begin
                nxt_bus.ce_n   = 1'b0;
                nxt_bus.we_n   = ph_last;
                nxt_bus.dq_oe  = 1'b1;
                nxt_bus.addr   = addr_ff;
                nxt_bus.dq_out = {8'h00, first_code(op_ff)};
                if (ph_last) begin
                    if (two_cyc) begin
                        nxt_st = ST_W2;
                    end else if (op_ff == `MLC_OP_CLR_STAT) begin
                        nxt_st = ST_EXIT;
                    end else begin
                        nxt_st = ST_IDLE;
                    end
                end
            end
            ST_W2: begin
                nxt_bus.ce_n   = 1'b0;
                nxt_bus.we_n   = ph_last;
                nxt_bus.dq_oe  = 1'b1;
                nxt_bus.addr   = w2_addr;
                nxt_bus.dq_out = second_word(op_ff, data_ff);
                if (ph_last) begin
                    nxt_st = op_ff == `MLC_OP_RCFG ? ST_IDLE : ST_POLL;               // [R19]
                end
            end
            ST_POLL: begin
                // Output enable pulses high between reads to refresh status
                nxt_bus.ce_n = 1'b0;
                nxt_bus.oe_n = ph_last;                                               // [R11]
                if (ph_last && arm_ff && dev_ready) begin
                    nxt_st = ST_CHECK;
                end
            end
            ST_CHECK: begin
                nxt_bus.ce_n = 1'b0;
                nxt_bus.oe_n = 1'b0;
                if (ph_last) begin
                    nxt_st = series_ff ? ST_IDLE : ST_EXIT;                           // [R12]
                end
            end
            ST_EXIT: begin
                nxt_bus.ce_n   = 1'b0;
                nxt_bus.we_n   = ph_last;
                nxt_bus.dq_oe  = 1'b1;
                nxt_bus.dq_out = {8'h00, `MLC_CMD_RD_ARRAY};                          // [R13]
                if (ph_last) begin
                    nxt_st = ST_IDLE;
                end
            end
            ST_READ: begin
                // Single non-page access keeps array and status reads uniform
                nxt_bus.ce_n = 1'b0;
                nxt_bus.oe_n = 1'b0;                                                  // [R01]
                nxt_bus.addr = addr_ff;
                if (ph_last && arm_ff) begin
                    nxt_st = ST_IDLE;
                end
            end
            default: nxt_st = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff  <= ST_IDLE;
            ph_ff  <= 2'h0;
            bus_ff <= '{addr: 23'h0, dq_out: 16'h0, dq_oe: 1'b0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
        end else begin
            st_ff  <= nxt_st;
            ph_ff  <= (nxt_st != st_ff || ph_last) ? 2'h0 : ph_ff + 2'h1;
            bus_ff <= nxt_bus;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            op_ff     <= 3'h0;
            series_ff <= 1'b0;
            addr_ff   <= 23'h0;
            data_ff   <= 16'h0000;
            busy_ff   <= 1'b0;
            mask_ff   <= 3'h0;
        end else begin
            if (start) begin
                op_ff     <= reg_wdata[2:0];
                series_ff <= reg_wdata[3];
                if (reg_wdata[2:0] == `MLC_OP_RCFG) begin
                    data_ff[`MLC_RCFG_MODE_BIT] <= reg_wdata[15];
                end
            end
            if (reg_wr && reg_addr == `MLC_REG_ADDR) begin
                addr_ff <= reg_wdata[22:0];
            end
            if (reg_wr && reg_addr == `MLC_REG_DATA) begin
                data_ff <= reg_wdata[15:0];
            end
            if (reg_wr && reg_addr == `MLC_REG_MASK) begin
                mask_ff <= reg_wdata[2:0];
            end
            busy_ff <= nxt_st != ST_IDLE;
        end
    end

    // Pin data lags two flops: trust a sample only once a full phase of the state has passed
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            arm_ff <= 1'b0;
        end else begin
            arm_ff <= nxt_st == st_ff && (arm_ff || ph_last);
        end
    end

    // Status and data latched from synchronised pins; events sticky, set beats clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stat_ff  <= 8'h80;
            rdata_ff <= 16'h0000;
            evt_ff   <= 3'h0;
        end else begin
            if (st_ff == ST_CHECK && ph_last) begin
                stat_ff <= dq_s2_ff[7:0];                                             // [R14]
            end
            if (rd_done) begin
                rdata_ff <= dq_s2_ff;
            end
            evt_ff <= (evt_rd ? 3'h0 : evt_ff) | evt_set;
        end
    end

    wire [31:0] rd_mux =
        reg_addr == `MLC_REG_CTRL  ? {16'h0, data_ff[15], 14'h0, busy_ff} :
        reg_addr == `MLC_REG_ADDR  ? {9'h0, addr_ff} :
        reg_addr == `MLC_REG_DATA  ? {16'h0, data_ff} :
        reg_addr == `MLC_REG_STAT  ? {24'h0, stat_ff} :
        reg_addr == `MLC_REG_EVT   ? {29'h0, evt_ff} :
        reg_addr == `MLC_REG_MASK  ? {29'h0, mask_ff} :
        reg_addr == `MLC_REG_RDATA ? {16'h0, rdata_ff} : 32'h0;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 32'h0;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 32'h0;
        end
    end

    assign irq     = |(evt_ff & mask_ff);
    assign mem_bus = bus_ff;

    sequence setup_write_s;
        st_ff == ST_W1 && !bus_ff.we_n;
    endsequence

    setup_code_a: assert property (@(posedge clk) disable iff (rst)  // [R16]
        st_ff == ST_W1 && op_ff == `MLC_OP_PROG && !ph_last |=> bus_ff.dq_out[7:0] == `MLC_CMD_PROG)
        else $error("program setup code wrong");
    exit_code_a: assert property (@(posedge clk) disable iff (rst)  // [R13]
        st_ff == ST_EXIT && !ph_last |=> bus_ff.dq_out[7:0] == `MLC_CMD_RD_ARRAY && bus_ff.dq_oe)
        else $error("exit code not driven");
    rcfg_reserved_a: assert property (@(posedge clk) disable iff (rst)  // [R03]
        st_ff == ST_W2 && op_ff == `MLC_OP_RCFG && !ph_last |=> bus_ff.addr[14:1] == 14'h0)
        else $error("reserved config bits not zero");
    oe_toggle_a: assert property (@(posedge clk) disable iff (rst)  // [R11]
        st_ff == ST_POLL && ph_last && !dev_ready |=> bus_ff.oe_n ##1 !bus_ff.oe_n)
        else $error("output enable not toggled");
    poll_gate_a: assert property (@(posedge clk) disable iff (rst)  // [R17]
        st_ff == ST_POLL && nxt_st == ST_CHECK |-> dev_ready)
        else $error("left poll while busy");
    no_drive_read_a: assert property (@(posedge clk) disable iff (rst)  // [R01]
        !bus_ff.oe_n |-> !bus_ff.dq_oe)
        else $error("bus contention");
    clr_code_a: assert property (@(posedge clk) disable iff (rst)  // [R18]
        setup_write_s ##0 op_ff == `MLC_OP_CLR_STAT |-> bus_ff.dq_out[7:0] == `MLC_CMD_CLR_STAT)
        else $error("clear status code wrong");
    lock_code_a: assert property (@(posedge clk) disable iff (rst)  // [R04]
        setup_write_s ##0 op_ff == `MLC_OP_LOCK_SET |-> bus_ff.dq_out[7:0] == `MLC_CMD_LOCK_SET)
        else $error("lock setup code wrong");

    sequence read_sample_s;
        st_ff == ST_READ && ph_last && arm_ff;
    endsequence

    read_window_a: assert property (@(posedge clk) disable iff (rst)  // [R01]
        read_sample_s |-> !bus_ff.oe_n && !bus_ff.ce_n && !$past(bus_ff.oe_n, 2))
        else $error("array read sampled outside output enable");
    poll_armed_a: assert property (@(posedge clk) disable iff (rst)  // [R11]
        st_ff == ST_POLL && nxt_st == ST_CHECK |-> arm_ff && !$past(bus_ff.oe_n, 2))
        else $error("ready taken from stale sample");
endmodule

// >>> hw/mlc_pkg.sv
// Types for the memory command controller
package mlc_pkg;
    typedef struct packed {
        logic [22:0] addr;
        logic [15:0] dq_out;
        logic        dq_oe;
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
    } mlc_bus_s;
    typedef enum logic [3:0] {
        ST_IDLE, ST_W1, ST_W2, ST_POLL, ST_CHECK, ST_CLR, ST_EXIT, ST_READ
    } mlc_st_e;
endpackage

// >>> testbench/mlc_dev_model.sv
// Behavioural model of the memory device behind the host controller
module mlc_dev_model (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire mlc_pkg::mlc_bus_s bus,
    input  wire logic [7:0]        busy_len,
    output logic [15:0]            dq,
    output logic                   ready_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    import mlc_pkg::*;
    logic [15:0] mem [0:255];
    logic        lock [0:127];
    logic [7:0]  sr, pend, busy_cnt, sr_lat;
    logic [15:0] rcfg, last;
    logic        stat_mode, we_q, lat_busy;
    wire         busy  = busy_cnt != 8'h00;
    wire  [6:0]  blk   = bus.addr[22:16];
    wire  [15:0] d     = bus.dq_out;
    wire         drive = !bus.ce_n && !bus.oe_n && !bus.dq_oe;
    // Busy status drives only the ready flag; the rest floats
    wire  [15:0] sr_out = lat_busy ? {9'h000, ~last[6:0]} : {8'h00, sr_lat};
    assign ready_pin = !busy;
    // Page and single reads return the same word here; status is single only
    assign dq = drive ? (stat_mode ? sr_out : mem[bus.addr[7:0]]) : ~last;
    // Latch after the edge settles so a write ending on the same clock is seen
    always @(negedge bus.oe_n) begin
        #1;
        lat_busy = busy;
        sr_lat   = sr;
    end
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_cnt  <= 8'h00;
            pend      <= 8'h00;
            stat_mode <= 1'b0;
            sr        <= 8'h80;
            rcfg      <= 16'h0000;
            last      <= 16'h0000;
            we_q      <= 1'b1;
            for (int i = 0; i < 128; i++) lock[i] <= 1'b0;
        end else begin
            last <= dq;
            we_q <= bus.we_n;
            if (busy) busy_cnt <= busy_cnt - 8'h01;
            // Latch only on write completion, chip-select edges leave it alone
            if (bus.we_n && !we_q && !bus.ce_n) begin
                pend <= 8'h00;
                if (pend == 8'h40) begin
                    if (lock[blk]) sr <= sr | 8'h12;
                    else mem[bus.addr[7:0]] <= d;
                    busy_cnt  <= busy_len;
                    stat_mode <= 1'b1;
                end else if (pend == 8'h60) begin
                    if (d[7:0] == 8'h01) lock[blk] <= 1'b1;
                    if (d[7:0] == 8'hd0) for (int i = 0; i < 128; i++) lock[i] <= 1'b0;
                    if (d[7:0] == 8'h03) rcfg <= bus.addr[15:0];
                    else begin
                        busy_cnt  <= busy_len;
                        stat_mode <= 1'b1;
                    end
                end else begin
                    if (d[7:0] == 8'h40) pend <= 8'h40;
                    if (d[7:0] == 8'h60 && !busy) pend <= 8'h60;
                    if (d[7:0] == 8'h50) sr <= sr & 8'hc5;
                    if (d[7:0] == 8'h70) stat_mode <= 1'b1;
                    if (d[7:0] == 8'hff) stat_mode <= 1'b0;
                end
            end
        end
    end
endmodule

// >>> testbench/mlc_host_tb_top.sv
// Register-level testbench for the memory host controller
`include "mlc_cfg.svh"
module mlc_host_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import mlc_pkg::*;
    logic        clk       = 1'b0;
    logic        rst       = 1'b1;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [3:0]  reg_addr  = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic [7:0]  busy_len  = 8'h01;
    logic [31:0] reg_rdata, rd_val;
    logic        irq, ready_pin;
    logic [15:0] dq;
    mlc_bus_s    bus;
    int          error_cnt   = 0;
    int          comparisons = 0;
    always #50 clk = ~clk;
    mlc_host DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .mem_bus(bus), .mem_dq_in(dq),
        .mem_ready_pin(ready_pin));
    mlc_dev_model DEV (.clk(clk), .rst(rst), .bus(bus), .busy_len(busy_len), .dq(dq), .ready_pin(ready_pin));
    task automatic results;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask
    // Extra control write lands while busy and must be dropped
    task automatic run_op(input logic [22:0] a, input logic [15:0] v, input logic [31:0] ctrl,
                          input logic [31:0] extra);
        int n = 0;
        wr(`MLC_REG_ADDR, {9'h000, a});
        wr(`MLC_REG_DATA, {16'h0000, v});
        wr(`MLC_REG_CTRL, ctrl);
        if (extra != 32'h0) wr(`MLC_REG_CTRL, extra);
        rd(`MLC_REG_CTRL);
        while (rd_val[0] !== 1'b0) begin
            n++;
            if (n > 3000) begin
                error_cnt++;
                results;
            end
            rd(`MLC_REG_CTRL);
        end
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(`MLC_REG_STAT);
        chk(32'h80, rd_val);
        chk(32'h0, {31'h0, irq});
        chk(32'h0, {31'h0, DEV.stat_mode});
        wr(`MLC_REG_MASK, 32'h4);
        run_op(23'h010000, 16'h0, `MLC_OP_LOCK_SET, 32'h0);
        chk(32'h1, {31'h0, DEV.lock[1]});
        rd(`MLC_REG_STAT);
        chk(32'h80, rd_val);
        rd(`MLC_REG_EVT);
        busy_len <= 8'h40;
        run_op(23'h010005, 16'ha5a5, `MLC_OP_PROG, 32'h0);
        rd(`MLC_REG_STAT);
        chk(32'h92, rd_val);
        chk(32'h1, {31'h0, irq});
        rd(`MLC_REG_EVT);
        #1 chk(32'h0, {31'h0, irq});
        busy_len <= 8'h01;
        run_op(23'h000007, 16'h1234, 32'h8 | `MLC_OP_PROG, 32'h0);
        rd(`MLC_REG_STAT);
        chk(32'h92, rd_val);
        chk(32'h1234, {16'h0, DEV.mem[7]});
        chk(32'h1, {31'h0, DEV.stat_mode});
        run_op(23'h0, 16'h0, `MLC_OP_CLR_STAT, 32'h0);
        chk(32'h80, {24'h0, DEV.sr});
        busy_len <= 8'hc0;
        run_op(23'h020009, 16'h5a5a, `MLC_OP_PROG, `MLC_OP_LOCK_CLR);
        chk(32'h1, {31'h0, DEV.lock[1]});
        chk(32'h5a5a, {16'h0, DEV.mem[9]});
        chk(32'h0, {31'h0, DEV.stat_mode});
        busy_len <= 8'h01;
        run_op(23'h0, 16'h0, `MLC_OP_LOCK_CLR, 32'h0);
        chk(32'h0, {31'h0, DEV.lock[1]});
        run_op(23'h010003, 16'hbeef, `MLC_OP_PROG, 32'h0);
        rd(`MLC_REG_STAT);
        chk(32'h80, rd_val);
        chk(32'hbeef, {16'h0, DEV.mem[3]});
        run_op(23'h008000, 16'h0, 32'h8000 | `MLC_OP_RCFG, 32'h0);
        chk(32'h1, {31'h0, DEV.rcfg[15]});
        chk(32'h0, {17'h0, DEV.rcfg[14:0]});
        rd(`MLC_REG_CTRL);
        chk(32'h8000, rd_val);
        run_op(23'h000007, 16'h0, `MLC_OP_READ, 32'h0);
        rd(`MLC_REG_RDATA);
        chk(32'h1234, rd_val);
        rd(4'hf);
        chk(32'h0, rd_val);
        results;
    end
    initial begin
        repeat (100000) @(posedge clk);
        error_cnt++;
        results;
    end
endmodule
